// ### verilog/sbmux_pkg.sv
// Constants shared by the sideband mux controller and its host-side I2C master.
package sbmux_pkg;
  localparam logic [6:0] ADDR_LOWER      = 7'h5C;
  localparam logic [6:0] ADDR_UPPER      = 7'h5D;
  localparam logic [7:0] OFF_REVISION    = 8'h09;
  localparam logic [7:0] OFF_ENABLE      = 8'h0A;
  localparam logic [7:0] OFF_ROUTE       = 8'h0B;
  localparam int         ENABLE_BIT      = 1;
  localparam int         SWAP_BIT        = 0;
  localparam logic [7:0] REG_RESET       = 8'h00;
  localparam logic [7:0] PTR_RESET       = 8'h00;
  // Revision code is arbitrary.
  localparam logic [3:0] REV_CODE        = 4'h3;
  localparam logic [1:0] ROUTE_LANE_B    = 2'h0;
  localparam logic [1:0] ROUTE_AUDIO     = 2'h1;
  localparam logic [1:0] ROUTE_LANE_C    = 2'h2;
  localparam logic [1:0] ROUTE_LANE_A    = 2'h3;
  localparam logic [1:0] STRAP_LOW       = 2'h0;
  localparam logic [1:0] STRAP_MID       = 2'h1;
  localparam logic [1:0] STRAP_HIGH      = 2'h2;
  // Host bit clock divider: SCL half period in system clocks.
  localparam int         HALF_PERIOD     = 8;
  // Host control register offsets on the software port.
  localparam logic [2:0] HOFF_CMD        = 3'h0;
  localparam logic [2:0] HOFF_STATUS     = 3'h1;
  localparam logic [2:0] HOFF_RDATA      = 3'h2;
  localparam int         CMD_START       = 8;
  localparam int         CMD_STOP        = 9;
  localparam int         CMD_READ        = 10;
  localparam int         CMD_NACK        = 11;
endpackage

// ### verilog/sbmux_if.sv
// Two-wire link between the host master and the mux controller.
interface sbmux_if;
  logic scl;
  logic sda_host_out;
  logic sda_host_oe_n;
  logic sda_dev_out;
  logic sda_dev_oe_n;
  logic sda_in;
  assign sda_in = (sda_host_oe_n | sda_host_out) & (sda_dev_oe_n | sda_dev_out);
  modport host (output scl, output sda_host_out, output sda_host_oe_n, input sda_in);
  modport dev  (input scl, output sda_dev_out, output sda_dev_oe_n, input sda_in);
endinterface

// ### verilog/sbmux_dev.sv
// Mux controller end: I2C slave, register file and switch-path decode.
// Notes on behaviour
// - Paths conduct only with pin low and, in I2C mode, chip active.
// - Unselected ports stay high impedance.
// - Pin low, bit zero: shutdown, I2C alive.
// - Pin high holds reset; I2C does not answer.
// - Answer lower or upper seven-bit slave address.
// - Acknowledge write address on match.
// - First written byte loads register pointer.
// - Acknowledge every data byte; store only at Ah and Bh.
// - Read sends registers from pointer, MSB first.
// - Next read byte only after master acknowledge.
// - Address plus sub-address then stop sets pointer.
// - Pointer resets zero, increments per byte.
// - Host leaves reserved offsets untouched.
// - Offset 9h read-only revision, upper nibble zero.
// - Offset Ah bit 1 chip-active, resets zero.
// - Offset Ah bit 0 orientation swap.
// - Offset Bh bits 1-0 route select.
// - Strap mid lower address, high upper address.
// - Strap low selects pin-configuration mode.
// - Routing from registers or pins by mode.
// - Swap affects high-speed lanes only.
//
// Added by the designer: strobed register access.
module sbmux_dev
(
  input  wire logic       clk,
  input  wire logic       reset,
  sbmux_if.dev            link,
  input  wire logic       switch_off_pin_n,
  input  wire logic [1:0] mode_strap,
  input  wire logic       route_pin_low,
  input  wire logic       route_pin_high,
  input  wire logic       orient_pin,
  output logic            lane_a_on,
  output logic            lane_a_swap,
  output logic            lane_b_on,
  output logic            lane_b_swap,
  output logic            lane_c_on,
  output logic            lane_c_swap,
  output logic            audio_on,
  output logic            chip_ready
);

  typedef enum logic [4:0]
  {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_WR   = 5'h04,
    ST_RD   = 5'h08,
    ST_RACK = 5'h10
  } sbmux_state_t;

  typedef struct packed
  {
    sbmux_state_t st;
    logic         scl_d;
    logic         sda_d;
    logic [3:0]   bitn;
    logic [7:0]   sh;
    logic         ack;
    logic         rw;
    logic         have_ptr;
    logic [7:0]   ptr;
    logic         enable;
    logic         swap;
    logic [1:0]   route;
    logic         sda_oe_n;
    logic         sda_out;
    logic [5:0]   paths;
    logic         ready;
  } sbmux_dev_t;

  sbmux_dev_t r;
  sbmux_dev_t next_r;
  logic [7:0] rd_byte;
  logic [6:0] my_addr;
  logic       i2c_mode;
  logic [1:0] sel;
  logic       sw;
  logic       live;

  ////////////////////////////////////////////////////////////////////////////////
  // Register read mux and mode decode.
  always_comb
  begin
    case (r.ptr)
      sbmux_pkg::OFF_REVISION: rd_byte = {4'h0, sbmux_pkg::REV_CODE};
      sbmux_pkg::OFF_ENABLE:   rd_byte = {6'h00, r.enable, r.swap};
      sbmux_pkg::OFF_ROUTE:    rd_byte = {6'h00, r.route};
      default:                 rd_byte = 8'h00;
    endcase
    my_addr  = (mode_strap == sbmux_pkg::STRAP_HIGH) ? sbmux_pkg::ADDR_UPPER : sbmux_pkg::ADDR_LOWER;
    i2c_mode = (mode_strap != sbmux_pkg::STRAP_LOW);
    sel      = i2c_mode ? r.route : {route_pin_high, route_pin_low};
    sw       = i2c_mode ? r.swap : orient_pin;
    live     = !switch_off_pin_n && (!i2c_mode || r.enable);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Slave sequencer.
  always_comb
  begin
    next_r       = r;
    next_r.scl_d = link.scl;
    next_r.sda_d = link.sda_in;
    next_r.paths = 6'h00;
    next_r.ready = !switch_off_pin_n;
    if (live)
    begin
      case (sel)
        sbmux_pkg::ROUTE_LANE_B: next_r.paths = {2'b00, 2'b00, 1'b1, sw};
        sbmux_pkg::ROUTE_AUDIO:  next_r.paths = {2'b00, 2'b10, 2'b00};
        sbmux_pkg::ROUTE_LANE_C: next_r.paths = {2'b00, 2'b01, 2'b00};
        default:                 next_r.paths = {1'b1, sw, 2'b00, 2'b00};
      endcase
    end
    if (link.scl && r.scl_d && r.sda_d && !link.sda_in)
    begin
      next_r.st       = ST_ADDR;                                                    // Start or repeated start.
      next_r.bitn     = 4'h0;
      next_r.ack      = 1'b0;
      next_r.have_ptr = 1'b0;
      next_r.sda_oe_n = 1'b1;
    end
    else if (link.scl && r.scl_d && !r.sda_d && link.sda_in)
    begin
      next_r.st       = ST_IDLE;
      next_r.sda_oe_n = 1'b1;
    end
    else if (link.scl && !r.scl_d && r.st != ST_IDLE)
    begin
      if (r.bitn < 4'h8)
      begin
        next_r.sh   = {r.sh[6:0], link.sda_in};
        next_r.bitn = r.bitn + 4'h1;
      end
      else if (r.st == ST_RD && link.sda_in)
        next_r.st = ST_IDLE;
      else
        next_r.bitn = 4'h0;
    end
    else if (!link.scl && r.scl_d && r.st != ST_IDLE)
    begin
      next_r.sda_oe_n = 1'b1;
      if (r.bitn == 4'h8 && r.st != ST_RD)
      begin
        next_r.ack = 1'b0;
        if (r.st == ST_ADDR)
        begin
          if (r.sh[7:1] == my_addr)
          begin
            next_r.ack = 1'b1;
            next_r.rw  = r.sh[0];
          end
          else
            next_r.st = ST_IDLE;
        end
        else
        begin
          next_r.ack = 1'b1;
          if (!r.have_ptr)
          begin
            next_r.ptr      = r.sh;
            next_r.have_ptr = 1'b1;
          end
          else
          begin
            if (r.ptr == sbmux_pkg::OFF_ENABLE)
            begin
              next_r.enable = r.sh[sbmux_pkg::ENABLE_BIT];
              next_r.swap   = r.sh[sbmux_pkg::SWAP_BIT];
            end
            if (r.ptr == sbmux_pkg::OFF_ROUTE)
              next_r.route = r.sh[1:0];
            next_r.ptr = r.ptr + 8'h01;
          end
        end
        if (next_r.ack)
        begin
          next_r.sda_oe_n = 1'b0;
          next_r.sda_out  = 1'b0;
        end
      end
      else if (r.bitn == 4'h0 && r.ack)
      begin
        next_r.ack = 1'b0;
        if (r.st == ST_ADDR)
          next_r.st = r.rw ? ST_RD : ST_WR;
        if (r.st == ST_ADDR && r.rw || r.st == ST_RD)
        begin
          next_r.st       = ST_RD;
          next_r.sh       = rd_byte;
          next_r.sda_oe_n = rd_byte[7];
          next_r.sda_out  = 1'b0;
          next_r.ptr      = r.ptr + 8'h01;
        end
      end
      else if (r.st == ST_RD && r.bitn < 4'h8)
      begin
        next_r.sda_oe_n = r.sh[7];
        next_r.sda_out  = 1'b0;
      end
      else if (r.st == ST_RD && r.bitn == 4'h8)
        next_r.ack = 1'b1;
    end
    if (r.st == ST_RD && r.bitn == 4'h8 && link.scl && !r.scl_d && !link.sda_in)
      next_r.bitn = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register; the switch-off pin acts as a reset.
  always_ff @(posedge clk)
  begin
    if (reset || switch_off_pin_n)
    begin
      r          <= '0;
      r.st       <= ST_IDLE;
      r.scl_d    <= 1'b1;
      r.sda_d    <= 1'b1;
      r.sda_oe_n <= 1'b1;
      r.sda_out  <= 1'b1;
      r.ptr      <= sbmux_pkg::PTR_RESET;
      r.enable   <= sbmux_pkg::REG_RESET[sbmux_pkg::ENABLE_BIT];
      r.swap     <= sbmux_pkg::REG_RESET[sbmux_pkg::SWAP_BIT];
      r.route    <= sbmux_pkg::REG_RESET[1:0];
    end
    else
      r <= next_r;
  end

  assign link.sda_dev_oe_n = r.sda_oe_n;
  assign link.sda_dev_out  = r.sda_out;
  assign lane_a_on         = r.paths[5];
  assign lane_a_swap       = r.paths[4];
  assign lane_c_on         = r.paths[2];
  assign lane_c_swap       = 1'b0;
  assign audio_on          = r.paths[3];
  assign lane_b_on         = r.paths[1];
  assign lane_b_swap       = r.paths[0];
  assign chip_ready        = r.ready;

endmodule

// ### verilog/sbmux_host.sv
// Host end: byte-level I2C master driven from a software command port.
module sbmux_host
(
  input  wire logic       clk,
  input  wire logic       reset,
  sbmux_if.host           link,
  input  wire logic [2:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic [15:0]     rdata
);

  typedef enum logic [5:0]
  {
    H_IDLE  = 6'h01,
    H_START = 6'h02,
    H_BITS  = 6'h04,
    H_ACK   = 6'h08,
    H_STOP  = 6'h10,
    H_DONE  = 6'h20
  } sbmux_hstate_t;

  typedef struct packed
  {
    sbmux_hstate_t st;
    logic [3:0]    div;
    logic [1:0]    ph;
    logic [3:0]    bitn;
    logic [7:0]    sh;
    logic [3:0]    cmd;
    logic          got_ack;
    logic [7:0]    rx;
    logic          scl;
    logic          sda_oe_n;
    logic [15:0]   rdata;
  } sbmux_host_t;

  sbmux_host_t r;
  sbmux_host_t next_r;
  logic        tick;
  logic        busy;

  ////////////////////////////////////////////////////////////////////////////////
  // Command issue, quarter-bit phases and status read.
  always_comb
  begin
    next_r   = r;
    busy     = (r.st != H_IDLE);
    tick     = (r.div == 4'(sbmux_pkg::HALF_PERIOD / 2 - 1));
    next_r.div = (busy && !tick) ? r.div + 4'h1 : 4'h0;
    if (rd)
      case (addr)
        sbmux_pkg::HOFF_STATUS: next_r.rdata = {14'h0000, r.got_ack, busy};
        sbmux_pkg::HOFF_RDATA:  next_r.rdata = {8'h00, r.rx};
        default:                next_r.rdata = 16'h0000;
      endcase
    if (wr && addr == sbmux_pkg::HOFF_CMD && !busy)
    begin
      next_r.sh   = wdata[7:0];
      next_r.cmd  = wdata[11:8];
      next_r.bitn = 4'h0;
      next_r.ph   = 2'h0;
      next_r.st   = wdata[sbmux_pkg::CMD_START] ? H_START : H_BITS;
    end
    else if (busy && tick)
    begin
      next_r.ph = r.ph + 2'h1;
      case (r.st)
        H_START:
        begin
          if (r.ph == 2'h0)
          begin
            next_r.sda_oe_n = 1'b1;
            next_r.scl      = 1'b1;
          end
          if (r.ph == 2'h2)
            next_r.sda_oe_n = 1'b0;
          if (r.ph == 2'h3)
          begin
            next_r.scl = 1'b0;
            next_r.st  = H_BITS;
          end
        end
        H_BITS:
        begin
          if (r.ph == 2'h0) next_r.sda_oe_n = r.cmd[2] | r.sh[7];
          if (r.ph == 2'h1) next_r.scl = 1'b1;
          if (r.ph == 2'h2) next_r.rx = {r.rx[6:0], link.sda_in};
          if (r.ph == 2'h3)
          begin
            next_r.scl  = 1'b0;
            next_r.sh   = {r.sh[6:0], 1'b1};
            next_r.bitn = r.bitn + 4'h1;
            if (r.bitn == 4'h7) next_r.st = H_ACK;
          end
        end
        H_ACK:
        begin
          if (r.ph == 2'h0) next_r.sda_oe_n = !r.cmd[2] | r.cmd[3];
          if (r.ph == 2'h1) next_r.scl = 1'b1;
          if (r.ph == 2'h2) next_r.got_ack = !link.sda_in;
          if (r.ph == 2'h3)
          begin
            next_r.scl = 1'b0;
            next_r.st  = r.cmd[1] ? H_STOP : H_DONE;
          end
        end
        H_STOP:
        begin
          if (r.ph == 2'h0) next_r.sda_oe_n = 1'b0;
          if (r.ph == 2'h1) next_r.scl = 1'b1;
          if (r.ph == 2'h2) next_r.sda_oe_n = 1'b1;
          if (r.ph == 2'h3) next_r.st = H_DONE;
        end
        H_DONE:  next_r.st = H_IDLE;
        default: next_r.st = H_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      r          <= '0;
      r.st       <= H_IDLE;
      r.scl      <= 1'b1;
      r.sda_oe_n <= 1'b1;
    end
    else
      r <= next_r;
  end

  assign link.scl           = r.scl;
  assign link.sda_host_out  = 1'b0;
  assign link.sda_host_oe_n = r.sda_oe_n;
  assign rdata              = r.rdata;

endmodule

// ### testbench/sbmux_assertions.sv
// Concurrent checks on the link and the switch-path outputs of the mux controller.
module sbmux_assertions
(
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       scl,
  input wire logic       sda_dev_oe_n,
  input wire logic       switch_off_pin_n,
  input wire logic [1:0] mode_strap,
  input wire logic       route_pin_low,
  input wire logic       route_pin_high,
  input wire logic       orient_pin,
  input wire logic       lane_a_on,
  input wire logic       lane_a_swap,
  input wire logic       lane_b_on,
  input wire logic       lane_b_swap,
  input wire logic       lane_c_on,
  input wire logic       audio_on
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       pin_mode;
  logic [1:0] pins;
  logic [3:0] paths;
  assign pin_mode = !switch_off_pin_n && mode_strap == sbmux_pkg::STRAP_LOW;
  assign pins     = {route_pin_high, route_pin_low};
  assign paths    = {lane_a_on, lane_b_on, lane_c_on, audio_on};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  off_pin_paths_a: assert property (switch_off_pin_n |=> paths == 4'h0)
    else $error("path on while switch-off pin high");
  one_path_a: assert property ($onehot0(paths))
    else $error("more than one path on");
  path_cause_a: assert property (paths != 4'h0 |-> !$past(switch_off_pin_n))
    else $error("path on without pin enable");
  swap_on_a: assert property ((lane_a_swap |-> lane_a_on) and (lane_b_swap |-> lane_b_on))
    else $error("swap on an unselected lane");
  pin_lane_a_a: assert property (pin_mode && pins == 2'h3 |=> lane_a_on && lane_a_swap == $past(orient_pin))
    else $error("pin mode lane a wrong");
  pin_lane_b_a: assert property (pin_mode && pins == 2'h0 |=> lane_b_on && lane_b_swap == $past(orient_pin))
    else $error("pin mode lane b wrong");
  pin_audio_a: assert property (pin_mode && pins == 2'h1 |=> audio_on)
    else $error("pin mode audio wrong");
  pin_lane_c_a: assert property (pin_mode && pins == 2'h2 |=> lane_c_on)
    else $error("pin mode lane c wrong");
  off_pin_sda_a: assert property (switch_off_pin_n [*2] |-> sda_dev_oe_n)
    else $error("data line driven while held off");
  sda_scl_low_a: assert property ($changed(sda_dev_oe_n) |-> !scl)
    else $error("data line changed while clock high");
  ////////////////////////////////////////
  cover property (lane_a_on && lane_a_swap);
  cover property (pin_mode && audio_on);
  cover property (!sda_dev_oe_n && scl);
endmodule

// ### testbench/sideband_mux_i2c_control_tb_top.sv
// Self-checking bench joining the host master and the mux controller over the link.
module sideband_mux_i2c_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] C_S = 12'h100;
  localparam logic [11:0] C_P = 12'h200;
  localparam logic [11:0] C_R = 12'h400;
  localparam logic [11:0] C_N = 12'h800;
  logic        clk;
  logic        reset;
  logic        switch_off_pin_n;
  logic [1:0]  mode_strap;
  logic        route_pin_low;
  logic        route_pin_high;
  logic        orient_pin;
  logic [6:0]  lanes;
  logic        chip_ready;
  logic [2:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic [6:0]  dev_addr;
  logic        ack;
  logic [7:0]  got;
  int          mreg [256];
  int          mptr;
  int unsigned rnd = 26;
  int          mismatches;
  int          checks;
  int          cycles;
  sbmux_if sbmux_if_i ();
  sbmux_host sbmux_host_i (.clk(clk), .reset(reset), .link(sbmux_if_i), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata));
  sbmux_dev sbmux_dev_i (.clk(clk), .reset(reset), .link(sbmux_if_i), .switch_off_pin_n(switch_off_pin_n),
    .mode_strap(mode_strap), .route_pin_low(route_pin_low), .route_pin_high(route_pin_high), .orient_pin(orient_pin),
    .lane_a_on(lanes[6]), .lane_a_swap(lanes[5]), .lane_b_on(lanes[4]), .lane_b_swap(lanes[3]),
    .lane_c_on(lanes[2]), .lane_c_swap(lanes[1]), .audio_on(lanes[0]), .chip_ready(chip_ready));
  sbmux_assertions sbmux_assertions_i (.clk(clk), .reset(reset), .scl(sbmux_if_i.scl),
    .sda_dev_oe_n(sbmux_if_i.sda_dev_oe_n), .switch_off_pin_n(switch_off_pin_n), .mode_strap(mode_strap),
    .route_pin_low(route_pin_low), .route_pin_high(route_pin_high), .orient_pin(orient_pin),
    .lane_a_on(lanes[6]), .lane_a_swap(lanes[5]), .lane_b_on(lanes[4]), .lane_b_swap(lanes[3]),
    .lane_c_on(lanes[2]), .audio_on(lanes[0]));
  ////////////////////////////////////////
  function automatic logic [7:0] nxt();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd[7:0];
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic mreset();
    foreach (mreg[i])
      mreg[i] = 0;
    mreg[sbmux_pkg::OFF_REVISION] = sbmux_pkg::REV_CODE;
    mptr = 0;
  endtask
  task automatic bus(input logic [2:0] a, input logic [15:0] d, input logic w);
    @(posedge clk);
    wr    <= w;
    rd    <= !w;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask
  task automatic xfer(input logic [11:0] cmd);
    int n;
    bus(sbmux_pkg::HOFF_CMD, {4'h0, cmd}, 1'b1);
    n = 0;
    do
    begin
      bus(sbmux_pkg::HOFF_STATUS, 16'h0000, 1'b0);
      n++;
    end
    while (rdata[0] !== 1'b0 && n < 500);
    check({7'h0, rdata[0]}, 8'h00);
    ack = rdata[1];
    bus(sbmux_pkg::HOFF_RDATA, 16'h0000, 1'b0);
    got = rdata[7:0];
  endtask
  task automatic wr_regs(input int sub, input int n, input int d0, input int d1);
    xfer(C_S | 12'({dev_addr, 1'b0}));
    check({7'h0, ack}, 8'h01);
    xfer(12'(sub) | (n == 0 ? C_P : 12'h000));
    check({7'h0, ack}, 8'h01);
    mptr = sub;
    for (int i = 0; i < n; i++)
    begin
      xfer(12'(i == 0 ? d0 : d1) | (i == n - 1 ? C_P : 12'h000));
      check({7'h0, ack}, 8'h01);
      if (mptr == sbmux_pkg::OFF_ENABLE || mptr == sbmux_pkg::OFF_ROUTE)
        mreg[mptr] = (i == 0 ? d0 : d1) % 4;
      mptr++;
    end
  endtask
  task automatic rd_regs(input int n);
    xfer(C_S | 12'({dev_addr, 1'b1}));
    check({7'h0, ack}, 8'h01);
    for (int i = 0; i < n; i++)
    begin
      xfer(C_R | (i == n - 1 ? C_N | C_P : 12'h000));
      check(got, 8'(mreg[mptr]));
      mptr++;
    end
  endtask
  task automatic check_paths();
    int         rt;
    int         sw;
    int         on;
    logic [7:0] e;
    rt = mreg[sbmux_pkg::OFF_ROUTE];
    sw = mreg[sbmux_pkg::OFF_ENABLE] % 2;
    on = mreg[sbmux_pkg::OFF_ENABLE] / 2;
    if (mode_strap == sbmux_pkg::STRAP_LOW)
    begin
      rt = {route_pin_high, route_pin_low};
      sw = orient_pin;
      on = 1;
    end
    if (switch_off_pin_n)
      on = 0;
    e = {1'b0, on && rt == 3, on && rt == 3 && sw, on && rt == 0, on && rt == 0 && sw, on && rt == 2, 1'b0, on && rt == 1};
    check({1'b0, lanes}, e);
    check({7'h0, chip_ready}, {7'h0, !switch_off_pin_n});
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever
      #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      mismatches++;
      report_and_stop();
    end
  end
  initial
  begin
    reset            = 1'b1;
    switch_off_pin_n = 1'b0;
    mode_strap       = sbmux_pkg::STRAP_MID;
    {route_pin_high, route_pin_low, orient_pin} = 3'h0;
    addr             = 3'h0;
    wdata            = 16'h0000;
    wr               = 1'b0;
    rd               = 1'b0;
    dev_addr         = sbmux_pkg::ADDR_LOWER;
    mreset();
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rd_regs(12);
    check_paths();
    wr_regs(sbmux_pkg::OFF_REVISION, 0, 0, 0);
    rd_regs(3);
    // Only the three defined offsets are written; reserved ones are only read.
    for (int i = 0; i < 8; i++)
    begin
      wr_regs(sbmux_pkg::OFF_ENABLE, 2, (nxt() & 8'hFC) | 2 | i % 2, (nxt() & 8'hFC) | i / 2);
      check_paths();
      wr_regs(sbmux_pkg::OFF_REVISION, 1, nxt(), 0);
      rd_regs(2);
    end
    wr_regs(sbmux_pkg::OFF_ENABLE, 1, 8'hFD, 0);
    check_paths();
    rd_regs(2);
    @(posedge clk);
    mode_strap <= sbmux_pkg::STRAP_HIGH;
    xfer(C_S | C_P | 12'({sbmux_pkg::ADDR_LOWER, 1'b0}));
    check({7'h0, ack}, 8'h00);
    dev_addr = sbmux_pkg::ADDR_UPPER;
    wr_regs(sbmux_pkg::OFF_ENABLE, 1, 8'h03, 0);
    check_paths();
    @(posedge clk);
    mode_strap <= sbmux_pkg::STRAP_LOW;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      {route_pin_high, route_pin_low, orient_pin} <= 3'(i);
      repeat (2) @(posedge clk);
      #1;
      check_paths();
    end
    @(posedge clk);
    mode_strap       <= sbmux_pkg::STRAP_MID;
    switch_off_pin_n <= 1'b1;
    dev_addr = sbmux_pkg::ADDR_LOWER;
    repeat (2) @(posedge clk);
    #1;
    check_paths();
    xfer(C_S | C_P | 12'({sbmux_pkg::ADDR_LOWER, 1'b0}));
    check({7'h0, ack}, 8'h00);
    @(posedge clk);
    switch_off_pin_n <= 1'b0;
    mreset();
    rd_regs(12);
    check_paths();
    report_and_stop();
  end
endmodule
